//--- src/cic_capture_cfg.sv
/*
 * Input capture configuration for four timer channels: direction and
 * source select with write lock, digital input filters, capture event
 * prescalers, and the AXI4-Lite register slave that holds them.
 * Assumes all inputs are synchronous to aclk; the internal trigger
 * source is already a clean level from the slave-mode logic.
 */
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps

module cic_capture_cfg (
   // clock and reset
   input  logic                           aclk,
   input  logic                           aresetn,
   // axi4-lite write
   input  logic [cic_pkg::CIC_ADDR_W-1:0] awaddr,
   input  logic                           awvalid,
   output logic                           awready,
   input  logic [cic_pkg::CIC_DATA_W-1:0] wdata,
   input  logic [3:0]                     wstrb,
   input  logic                           wvalid,
   output logic                           wready,
   output logic [1:0]                     bresp,
   output logic                           bvalid,
   input  logic                           bready,
   // axi4-lite read
   input  logic [cic_pkg::CIC_ADDR_W-1:0] araddr,
   input  logic                           arvalid,
   output logic                           arready,
   output logic [cic_pkg::CIC_DATA_W-1:0] rdata,
   output logic [1:0]                     rresp,
   output logic                           rvalid,
   input  logic                           rready,
   // timer side
   input  logic [cic_pkg::CIC_NCH-1:0]    timer_input,
   input  logic                           internal_trigger_source,
   output logic [cic_pkg::CIC_NCH-1:0]    capture_pulse
);
   import cic_pkg::*;

   // ===================================================================
   // declarations
   cic_chcfg_t                cfg_r [CIC_NCH];
   cic_chcfg_t                wr_half [2];
   logic [CIC_NCH-1:0]        en_r;
   logic                      trig_int_r;
   logic [CIC_DIV_CNT_W-1:0]  div_cnt_r;
   logic [CIC_NCH-1:0]        filt_v;
   logic [CIC_NCH-1:0]        src_v;

   logic                      aw_hold_r;
   logic                      w_hold_r;
   logic                      awready_r;
   logic                      wready_r;
   logic                      bvalid_r;
   logic [1:0]                bresp_r;
   logic                      arready_r;
   logic                      rvalid_r;
   logic [1:0]                rresp_r;
   logic [CIC_DATA_W-1:0]     rdata_r;
   logic [CIC_ADDR_W-1:0]     waddr_r;
   logic [CIC_DATA_W-1:0]     wdata_r;
   logic [3:0]                wstrb_r;
   logic                      aw_hs;
   logic                      w_hs;
   logic                      ar_hs;
   logic                      do_wr;
   logic                      wr_ok;
   logic                      aw_hold_nxt;
   logic                      w_hold_nxt;
   logic                      bvalid_nxt;
   logic                      rvalid_nxt;
   logic [CIC_ADDR_W-1:0]     raddr_al;
   logic [CIC_DATA_W-1:0]     rd_word;
   logic                      rd_ok;

   // ===================================================================
   // axi4-lite write channel
   assign aw_hs       = awvalid && awready_r;
   assign w_hs        = wvalid && wready_r;
   assign ar_hs       = arvalid && arready_r;
   assign do_wr       = aw_hold_r && w_hold_r && !bvalid_r;
   assign aw_hold_nxt = aw_hs || (aw_hold_r && !do_wr);
   assign w_hold_nxt  = w_hs || (w_hold_r && !do_wr);
   assign bvalid_nxt  = do_wr || (bvalid_r && !bready);
   assign wr_ok       = waddr_r == CIC_OFS_MODE12
                     || waddr_r == CIC_OFS_MODE34
                     || waddr_r == CIC_OFS_ENABLE
                     || waddr_r == CIC_OFS_CTRL
                     || waddr_r == CIC_OFS_STATUS;

   // address and data are taken in either order, then written together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= CIC_RESP_OKAY;
         waddr_r   <= '0;
         wdata_r   <= '0;
         wstrb_r   <= '0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r  <= w_hold_nxt;
         bvalid_r  <= bvalid_nxt;
         // ready stays low until the response is gone: one write at a time
         awready_r <= !aw_hold_nxt && !bvalid_nxt;
         wready_r  <= !w_hold_nxt && !bvalid_nxt;
         if (aw_hs) begin
            waddr_r <= {awaddr[CIC_ADDR_W-1:2], 2'h0};
         end
         if (w_hs) begin
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (do_wr) begin
            bresp_r <= wr_ok ? CIC_RESP_OKAY : CIC_RESP_SLVERR;
         end
      end
   end

   assign wr_half[0] = cic_chcfg_t'(wdata_r[CIC_CFG_W-1:0]);
   assign wr_half[1] = cic_chcfg_t'(wdata_r[2*CIC_CFG_W-1:CIC_CFG_W]);

   // ===================================================================
   // mode registers: each byte lane holds one channel's fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int c = 0; c < CIC_NCH; c++) begin
            cfg_r[c] <= cic_chcfg_t'(
               CIC_MODE_RST[(c % 2)*CIC_CFG_W +: CIC_CFG_W]);
         end
      end else if (do_wr) begin
         for (int c = 0; c < CIC_NCH; c++) begin
            if (wstrb_r[c % 2] && waddr_r == ((c < 2) ? CIC_OFS_MODE12
                                                       : CIC_OFS_MODE34))
            begin
               cfg_r[c].filt <= wr_half[c % 2].filt;
               cfg_r[c].prescale_factor  <= wr_half[c % 2].prescale_factor;
               // direction is frozen while the channel runs
               if (!en_r[c]) begin
                  cfg_r[c].sel <= wr_half[c % 2].sel;
               end
            end
         end
      end
   end

   // channel enables and the internal trigger qualifier
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_r       <= '0;
         trig_int_r <= 1'b0;
      end else if (do_wr && wstrb_r[0]) begin
         if (waddr_r == CIC_OFS_ENABLE) begin
            en_r <= wdata_r[CIC_NCH-1:0];
         end
         if (waddr_r == CIC_OFS_CTRL) begin
            trig_int_r <= wdata_r[CIC_CTRL_TRIG];
         end
      end
   end

   // ===================================================================
   // axi4-lite read channel
   assign raddr_al   = {araddr[CIC_ADDR_W-1:2], 2'h0};
   assign rvalid_nxt = ar_hs || (rvalid_r && !rready);

   // read decode; upper bits of narrow registers read as zero
   always_comb begin
      rd_word = '0;
      rd_ok   = 1'b1;
      unique case (raddr_al)
         CIC_OFS_MODE12: rd_word[2*CIC_CFG_W-1:0] = {cfg_r[1], cfg_r[0]};
         CIC_OFS_MODE34: rd_word[2*CIC_CFG_W-1:0] = {cfg_r[3], cfg_r[2]};
         CIC_OFS_ENABLE: rd_word[CIC_NCH-1:0] = en_r;
         CIC_OFS_CTRL:   rd_word[CIC_CTRL_TRIG] = trig_int_r;
         CIC_OFS_STATUS: begin
            rd_word[CIC_ST_FILT_LSB +: CIC_NCH] = filt_v;
            rd_word[CIC_ST_SRC_LSB +: CIC_NCH]  = src_v;
         end
         default:        rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= CIC_RESP_OKAY;
         rdata_r   <= '0;
      end else begin
         rvalid_r  <= rvalid_nxt;
         arready_r <= !rvalid_nxt;
         if (ar_hs) begin
            rdata_r <= rd_word;
            rresp_r <= rd_ok ? CIC_RESP_OKAY : CIC_RESP_SLVERR;
         end
      end
   end

   assign awready = awready_r;
   assign wready  = wready_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign arready = arready_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;

   // ===================================================================
   // shared sampling divider: each filter picks every 2^k-th count
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_r <= '0;
      end else begin
         div_cnt_r <= div_cnt_r + CIC_DIV_CNT_W'(1);
      end
   end

   // ===================================================================
   // per-channel filter, source select, edge and prescaler
   for (genvar c = 0; c < CIC_NCH; c++) begin : g_ch
      localparam int PA = (c / 2) * 2;
      localparam int PB = PA + 1;
      logic [2:0]               dlog;
      logic [3:0]               flen;
      logic [CIC_DIV_CNT_W-1:0] dmask;
      logic                     smp;
      logic                     filt_r;
      logic [3:0]               flt_cnt_r;
      logic                     src_c;
      logic                     src_prev_r;
      logic                     rise;
      logic [CIC_PSC_CNT_W-1:0] psc_cnt_r;
      logic [CIC_PSC_CNT_W-1:0] psc_lim;
      logic [1:0]               psc_prev_r;
      logic                     cap_r;

      // same tables for every channel
      assign dlog  = CIC_FLT_DIV_LOG[cfg_r[c].filt];
      assign flen  = CIC_FLT_LEN[cfg_r[c].filt];
      assign dmask = CIC_DIV_CNT_W'((1 << dlog) - 1);
      assign smp   = (div_cnt_r & dmask) == '0;

      // a level change passes after N unbroken samples of the new level
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            filt_r    <= 1'b0;
            flt_cnt_r <= '0;
         end else if (smp) begin
            if (timer_input[c] == filt_r) begin
               flt_cnt_r <= '0;
            end else if (flt_cnt_r + 4'h1 >= flen) begin
               filt_r    <= timer_input[c];
               flt_cnt_r <= '0;
            end else begin
               flt_cnt_r <= flt_cnt_r + 4'h1;
            end
         end
      end

      // both channels of a pair map 01 and 10 alike
      always_comb begin
         unique case (cfg_r[c].sel)
            CIC_SEL_OUT:    src_c = 1'b0;
            CIC_SEL_PAIR_A: src_c = filt_v[PA];
            CIC_SEL_PAIR_B: src_c = filt_v[PB];
            CIC_SEL_TRC:    src_c = internal_trigger_source
                                    && trig_int_r;
         endcase
      end

      assign rise    = src_c && !src_prev_r && en_r[c]
                    && cfg_r[c].sel != CIC_SEL_OUT;
      assign psc_lim = CIC_PSC_CNT_W'((1 << cfg_r[c].prescale_factor) - 1);

      // counting restarts so the first capture keeps the ratio
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            src_prev_r <= 1'b0;
            psc_prev_r <= '0;
            psc_cnt_r  <= '0;
            cap_r      <= 1'b0;
         end else begin
            src_prev_r <= src_c;
            psc_prev_r <= cfg_r[c].prescale_factor;
            cap_r      <= 1'b0;
            if (!en_r[c] || cfg_r[c].prescale_factor != psc_prev_r) begin
               psc_cnt_r <= '0;
            end else if (rise) begin
               if (psc_cnt_r == psc_lim) begin
                  cap_r     <= 1'b1;
                  psc_cnt_r <= '0;
               end else begin
                  psc_cnt_r <= psc_cnt_r + CIC_PSC_CNT_W'(1);
               end
            end
         end
      end

      assign filt_v[c]        = filt_r;
      assign src_v[c]         = src_c;
      assign capture_pulse[c] = cap_r;
   end

   // ===================================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ch1_dir_lock_a: assert property (en_r[0] |=> $stable(cfg_r[0].sel))
      else $error("ch1 direction changed while enabled");
   ch2_dir_lock_a: assert property (en_r[1] |=> $stable(cfg_r[1].sel))
      else $error("ch2 direction changed while enabled");
   ch1_out_quiet_a: assert property (cfg_r[0].sel == CIC_SEL_OUT
      |=> !capture_pulse[0])
      else $error("ch1 captured as output");
   ch2_out_quiet_a: assert property (cfg_r[1].sel == CIC_SEL_OUT
      |=> !capture_pulse[1])
      else $error("ch2 captured as output");
   ch3_out_quiet_a: assert property (cfg_r[2].sel == CIC_SEL_OUT
      |=> !capture_pulse[2])
      else $error("ch3 captured as output");
   trc_gate_a: assert property ($past(cfg_r[0].sel) == CIC_SEL_TRC
      && !$past(trig_int_r) |-> !capture_pulse[0])
      else $error("trigger capture without internal trigger");
   psc_eighth_a: assert property (capture_pulse[0]
      && $past(cfg_r[0].prescale_factor) == CIC_PSC_DIV8
      |-> $past(g_ch[0].psc_cnt_r) == CIC_PSC_MAX)
      else $error("divide-by-8 capture at wrong count");
   psc_restart_a: assert property (!en_r[0] |=> g_ch[0].psc_cnt_r == '0)
      else $error("prescale count kept while disabled");
   flt_off_a: assert property ($past(aresetn)
      && $past(cfg_r[0].filt) == CIC_FLT_OFF
      |-> filt_v[0] == $past(timer_input[0]))
      else $error("unfiltered input not followed");
   flt_len_two_a: assert property ($past(cfg_r[0].filt) == CIC_FLT_D1N2
      && $past(cfg_r[0].filt, 2) == CIC_FLT_D1N2 && $changed(filt_v[0])
      |-> $past(timer_input[0]) == $past(timer_input[0], 2))
      else $error("filter passed change before two samples");
   flt_div32_a: assert property ($past(cfg_r[0].filt) == CIC_FLT_D32N5
      && $changed(filt_v[0]) |-> $past(div_cnt_r) == '0)
      else $error("filter sampled off its divider");
   mode34_reset_a: assert property (!$past(aresetn)
      |-> {cfg_r[3], cfg_r[2]} == CIC_MODE_RST)
      else $error("second mode register not reset");

endmodule // cic_capture_cfg

//--- src/cic_pkg.sv
/*
 * Shared constants and types for the capture input configuration block:
 * register offsets, field codes, filter tables and the per-channel
 * configuration carrier.
 * Assumes a 32-bit AXI4-Lite register bus and one timer kernel clock.
 */
// ======================================================================
// Notes on behaviour
// - ch1 direction 00 is output, 01 input one, 10 input two, 11 trigger.
// - ch1 direction takes writes only while ch1 is disabled.
// - the trigger source feeds a capture only with internal trigger on.
// - ch2 direction in bits 9:8 decodes like ch1.
// - ch2 direction takes writes only while ch2 is disabled.
// - prescale codes 00..11 capture every 1st, 2nd, 4th or 8th event.
// - filter code 0000 means no filtering, sampled every clock.
// - filter codes 0001..1001 pick the printed divider and length pairs.
// - codes 1010..1100 give divider 16; 1101..1111 give divider 32.
// - the filter samples at clock/divider and needs N equal samples.
// - ch2 prescale sits in bits 11:10 and ch2 filter in bits 15:12.
// - the ch3/ch4 mode register is at 0x1C, resets to 0, same layout.
// - ch3 direction sits in bits 1:0 and 00 makes it an output.

package cic_pkg;

   // ===================================================================
   // bus and sizes
   localparam int CIC_ADDR_W = 8;
   localparam int CIC_DATA_W = 32;
   localparam int CIC_NCH    = 4;
   localparam int CIC_CFG_W  = 8;

   // ===================================================================
   // register offsets
   localparam logic [7:0] CIC_OFS_MODE12 = 8'h18;
   localparam logic [7:0] CIC_OFS_MODE34 = 8'h1C;
   localparam logic [7:0] CIC_OFS_ENABLE = 8'h20;
   localparam logic [7:0] CIC_OFS_CTRL   = 8'h24;
   localparam logic [7:0] CIC_OFS_STATUS = 8'h28;

   localparam logic [15:0] CIC_MODE_RST    = 16'h0000;
   localparam int          CIC_CTRL_TRIG   = 0;
   localparam int          CIC_ST_FILT_LSB = 0;
   localparam int          CIC_ST_SRC_LSB  = 4;

   localparam logic [1:0] CIC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CIC_RESP_SLVERR = 2'h2;

   // ===================================================================
   // field codes
   localparam logic [1:0] CIC_SEL_OUT    = 2'h0;
   localparam logic [1:0] CIC_SEL_PAIR_A = 2'h1;
   localparam logic [1:0] CIC_SEL_PAIR_B = 2'h2;
   localparam logic [1:0] CIC_SEL_TRC    = 2'h3;
   localparam logic [1:0] CIC_PSC_DIV8   = 2'h3;
   localparam logic [2:0] CIC_PSC_MAX    = 3'h7;
   localparam logic [3:0] CIC_FLT_OFF    = 4'h0;
   localparam logic [3:0] CIC_FLT_D1N2   = 4'h1;
   localparam logic [3:0] CIC_FLT_D32N5  = 4'hD;

   // filter code -> log2 of sampling divider, and length N
   localparam int CIC_DIV_CNT_W = 5;
   localparam int CIC_PSC_CNT_W = 3;
   localparam logic [2:0] CIC_FLT_DIV_LOG [16] = '{
      3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
      3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
   localparam logic [3:0] CIC_FLT_LEN [16] = '{
      4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
      4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};

   // one half of a mode register
   typedef struct packed {
      logic [3:0] filt;
      logic [1:0] prescale_factor;
      logic [1:0] sel;
   } cic_chcfg_t;

endpackage

//--- testbench/cic_input_model.sv
/*
 * Model of the far side: the four timer input pins and the internal
 * trigger source level.
 * Assumes the bench calls its task; lines change just after a rising edge.
 */
`timescale 1ns/1ps

module cic_input_model (
   // clock
   input  logic       aclk,
   // lines towards the block
   output logic [3:0] timer_input,
   output logic       internal_trigger_source
);

   // ==================================================================
   // line drivers
   // all lines idle low; they are driven at all times, so never float
   initial begin
      timer_input             = 4'h0;
      internal_trigger_source = 1'b0;
   end

   // one high pulse on line ln (4 is the trigger): hi cycles, then lo
   task automatic pulse(input int ln, input int hi, input int lo);
      @(posedge aclk);
      if (ln == 4) internal_trigger_source <= 1'b1;
      else timer_input[ln] <= 1'b1;
      repeat (hi) @(posedge aclk);
      if (ln == 4) internal_trigger_source <= 1'b0;
      else timer_input[ln] <= 1'b0;
      repeat (lo) @(posedge aclk);
   endtask

endmodule // cic_input_model

//--- testbench/test_cic_capture_cfg.sv
/*
 * Self-checking bench for the capture input configuration block.
 * Assumes the package offsets and the input model beside it.
 */
`timescale 1ns/1ps

module test_cic_capture_cfg;
   import cic_pkg::*;

   // ==================================================================
   // signals
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready, trig;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb, tin, capture_pulse;
   logic [1:0]  bresp, rresp, r;
   int          n_errors, compares, cnt[4];
   typedef struct packed {
      logic [7:0] a; logic [31:0] w; logic [31:0] q; logic [1:0] e;
   } cic_row_t;
   // address, written, read back, response of both directions
   cic_row_t    rows[4] = '{
      '{8'h18, 32'h0000FFFF, 32'h0000FFFF, 2'h0},
      '{8'h18, 32'hFFFF1234, 32'h00001234, 2'h0},
      '{8'h1C, 32'h0000A5C3, 32'h0000A5C3, 2'h0},
      '{8'h30, 32'h00000001, 32'h00000000, 2'h2}};
   int          fdiv[16] = '{1,1,1,1,2,2,4,4,8,8,16,16,16,32,32,32};
   int          flen[16] = '{1,2,4,8,6,8,6,8,6,8,5,6,8,5,6,8};
   int          dexp[5]  = '{0,2,3,4,0};

   // ==================================================================
   // design and far-side model
   cic_capture_cfg u_cic_capture_cfg (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .timer_input(tin), .internal_trigger_source(trig),
      .capture_pulse(capture_pulse));
   cic_input_model u_cic_input_model (
      .aclk(aclk), .timer_input(tin), .internal_trigger_source(trig));

   // ==================================================================
   // clock and capture counters
   always #25 aclk = ~aclk;
   always @(posedge aclk)
      for (int i = 0; i < 4; i++)
         if (capture_pulse[i] === 1'b1) cnt[i]++;

   // ==================================================================
   // helpers
   task automatic chk(input string n, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   // both address and data offered at once, each released when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] dw,
                      output logic [1:0] rs);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= dw;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dw);
      logic [1:0] rs;
      axw(a, dw, rs);
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic pulses(input int ln, n, hi, lo);
      repeat (n) u_cic_input_model.pulse(ln, hi, lo);
   endtask

   // cleared away from the edge so the counter process never races it
   task automatic clr();
      @(negedge aclk);
      cnt = '{default: 0};
   endtask

   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask

   task automatic finish_test();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ==================================================================
   // watchdog: the whole run needs well under 20000 cycles
   initial begin
      repeat (60000) @(posedge aclk);
      n_errors++;
      finish_test();
   end

   // ==================================================================
   // main sequence
   initial begin
      {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CIC_OFS_MODE34);
      chk("mode34 reset", d, 32'h0);
      end_test("reset");
      foreach (rows[i]) begin
         axw(rows[i].a, rows[i].w, r);
         chk("bresp", 32'(r), 32'(rows[i].e));
         rd(rows[i].a);
         chk("rdata", d, rows[i].q);
         chk("rresp", 32'(r), 32'(rows[i].e));
      end
      end_test("table");
      for (int p = 0; p < 4; p++) begin
         wr(CIC_OFS_MODE12, 32'h0101 | 32'(p) << 2 | 32'(p) << 10);
         wr(CIC_OFS_ENABLE, 32'h3);
         clr();
         pulses(0, 8, 3, 3);
         chk("ch1 prescale", 32'(cnt[0]), 32'(8 >> p));
         chk("ch2 prescale", 32'(cnt[1]), 32'(8 >> p));
         wr(CIC_OFS_ENABLE, 32'h0);
      end
      end_test("prescale");
      wr(CIC_OFS_CTRL, 32'h1);
      for (int s = 0; s < 5; s++) begin
         if (s == 4) wr(CIC_OFS_CTRL, 32'h0);
         // last pass keeps the trigger source but drops the qualifier
         d = 32'h0101 * ((s == 4) ? 3 : s);
         wr(CIC_OFS_MODE12, d);
         wr(CIC_OFS_MODE34, d);
         wr(CIC_OFS_ENABLE, 32'hF);
         clr();
         pulses(0, 2, 3, 3);
         pulses(2, 2, 3, 3);
         pulses(1, 3, 3, 3);
         pulses(3, 3, 3, 3);
         pulses(4, 4, 3, 3);
         chk("ch1 source", 32'(cnt[0]), 32'(dexp[s]));
         chk("ch2 source", 32'(cnt[1]), 32'(dexp[s]));
         chk("ch3 source", 32'(cnt[2]), 32'(dexp[s]));
         chk("ch4 source", 32'(cnt[3]), 32'(dexp[s]));
         wr(CIC_OFS_ENABLE, 32'h0);
      end
      end_test("direction");
      // glitch one sample short of n is dropped (code 0 takes its one-cycle pulse), a long pulse is taken
      for (int f = 0; f < 16; f++) begin
         wr(CIC_OFS_MODE12, 32'h0101 | 32'(f) << 4 | 32'(f) << 12);
         wr(CIC_OFS_ENABLE, 32'h3);
         clr();
         u_cic_input_model.pulse(0, (f == 0) ? 1 : fdiv[f] * (flen[f] - 1),
                                 fdiv[f] * (flen[f] + 1));
         pulses(0, 1, fdiv[f] * (flen[f] + 1), fdiv[f] * (flen[f] + 1));
         chk("ch1 flt", cnt[0], 1 + (f == 0));
         chk("ch2 flt", cnt[1], 1 + (f == 0));
         wr(CIC_OFS_ENABLE, 32'h0);
      end
      end_test("filter");
      wr(CIC_OFS_MODE12, 32'h0101);
      wr(CIC_OFS_ENABLE, 32'h3);
      wr(CIC_OFS_MODE12, 32'hF2F2);
      rd(CIC_OFS_MODE12);
      chk("locked both", d, 32'hF1F1);
      wr(CIC_OFS_ENABLE, 32'h1);
      wr(CIC_OFS_MODE12, 32'h0202);
      rd(CIC_OFS_MODE12);
      chk("locked ch1", d, 32'h0201);
      end_test("lock");
      // five events then a disable must not shorten the next count of 8
      wr(CIC_OFS_ENABLE, 32'h0);
      wr(CIC_OFS_MODE12, 32'h000D);
      wr(CIC_OFS_ENABLE, 32'h1);
      pulses(0, 5, 3, 3);
      wr(CIC_OFS_ENABLE, 32'h0);
      wr(CIC_OFS_ENABLE, 32'h1);
      clr();
      pulses(0, 7, 3, 3);
      chk("restart 7", 32'(cnt[0]), 32'h0);
      pulses(0, 1, 3, 3);
      chk("restart 8", 32'(cnt[0]), 32'h1);
      end_test("restart");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CIC_OFS_MODE34);
      chk("mode34 rereset", d, 32'h0);
      end_test("second reset");
      finish_test();
   end

endmodule // test_cic_capture_cfg
